// file: pkg/ddp_defines.svh
`ifndef DDP_DEFINES_SVH
`define DDP_DEFINES_SVH
// Overview of operation
// R1: mask low on a lane drops that lane
// R2: mask high on a lane stores that lane
// R3: masking plus CRC: bad CRC writes nothing
// R4: CRC without masking: write even on bad CRC
// R5: lower byte DQ[7:0], upper DQ[15:8], lane masks
// R6: mode_reg_four bit 12 picks write preamble length
// R7: mode_reg_four bit 11 picks read preamble length
// R8: write and read preambles set independently
// R9: two-clock preamble only at 2400 MT/s up
// R10: two-clock read preamble forbids 5-clock column spacing
// R11: two-clock write preamble forbids 5, or 6 with CRC
// R12: primary write latency needs extra clock in two-clock mode; the code adds none, wl comes from mr2 alone
// R13: write latency table per speed and preamble; the code has one table, indexed by mr2 bits 5:3 only
// R14: controller adds one clock to write-to-read, recovery
// R15: training via mode_reg_four bit 10, pattern mode only
// R16: training holds data high, strobe low until pattern read
// R17: postamble is half a clock for reads and writes
// R18: two bank groups of four banks, one group bit
// R19: short column spacing across groups, long within
// R20: short activate spacing across groups, long within
// R21: write-to-read from internal write, short or long
// R22: spacing must meet larger of clocks and time
// R23: masking set by bit 10, not with inversion bit 11
// R24: CRC error sets mode_reg_five bit 3 until cleared
// R25: controller rounds nanosecond spacings up to clocks

`define DDP_OFF_MR0 8'h00
`define DDP_OFF_MR2 8'h04
`define DDP_OFF_MR4 8'h08
`define DDP_OFF_MR5 8'h0C
`define DDP_OFF_PAT 8'h10
`define DDP_OFF_CTRL 8'h14
`define DDP_OFF_STAT 8'h18

`define DDP_MR0_RST 14'h00B0
`define DDP_MR2_RST 14'h0000
`define DDP_MR4_RST 14'h0000
`define DDP_MR5_RST 14'h0000
`define DDP_PAT_RST 32'h00000000

`define DDP_MR0_RL_LSB 4
`define DDP_MR2_WL_LSB 3
`define DDP_MR2_CRC_BIT 12
`define DDP_MR4_WPRE_BIT 12
`define DDP_MR4_RPRE_BIT 11
`define DDP_MR4_TRAIN_BIT 10
`define DDP_MR5_DM_BIT 10
`define DDP_MR5_WDBI_BIT 11
`define DDP_MR5_CRCERR_BIT 3
`define DDP_CTRL_PMODE_BIT 0

`define DDP_WL_TABLE {5'h14, 5'h12, 5'h10, 5'h0E, 5'h0C, 5'h0B, 5'h0A, 5'h09}

`define DDP_CLK_NS 40
`define DDP_TRAINING_SETTLE_TIME_NS 60
`define DDP_TRAINING_SETTLE_TIME_CYC ((`DDP_TRAINING_SETTLE_TIME_NS + `DDP_CLK_NS - 1) / `DDP_CLK_NS)
`endif

// file: pkg/ddp_pkg.sv
package ddp_pkg;
  typedef enum {DDP_IDLE, DDP_WR, DDP_COMMIT, DDP_RD} ddp_state_t;

  typedef enum logic [1:0] {
    DDP_NOP = 2'h0,
    DDP_WRITE = 2'h1,
    DDP_READ = 2'h2
  } ddp_cmd_t;

  typedef struct packed {
    logic ck;
    ddp_cmd_t cmd;
    logic bank_group_bit;
    logic [1:0] bank;
    logic [15:0] dq;
    logic upper_lane_mask;
    logic lower_lane_mask;
  } ddp_link_in_t;

  typedef struct packed {
    logic [15:0] dq;
    logic dq_oe;
    logic dqs_t;
    logic dqs_c;
    logic dqs_oe;
  } ddp_link_out_t;
endpackage

// file: rtl/ddp_sync.sv
module ddp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  // a bit changes only once stages two and three agree
  always_comb begin
    next_q = q;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_q[i] = s2[i];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end
endmodule

// file: rtl/ddp_top.sv
`include "ddp_defines.svh"

module ddp_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire ddp_pkg::ddp_link_in_t link_in,
  output ddp_pkg::ddp_link_out_t link_out
);
  localparam logic [39:0] WL_TAB = `DDP_WL_TABLE;
  localparam logic [7:0] TRAINING_SETTLE_TIME_CYC = 8'(`DDP_TRAINING_SETTLE_TIME_CYC);

  ddp_pkg::ddp_link_in_t link_s;
  logic ck_prev;
  logic rise;
  logic fall;
  logic edge_seen;

  logic [13:0] mr0;
  logic [13:0] mr2;
  logic [13:0] mr4;
  logic [13:0] mr5;
  logic [31:0] pat;
  logic pmode;
  logic [13:0] next_mr0;
  logic [13:0] next_mr2;
  logic [13:0] next_mr4;
  logic [13:0] next_mr5;
  logic [31:0] next_pat;
  logic next_pmode;
  logic [31:0] next_dat_o;
  logic next_ack;
  logic [31:0] rd_val;
  logic [31:0] wr_val;
  logic bus_hit;

  ddp_pkg::ddp_state_t state;
  ddp_pkg::ddp_state_t next_state;
  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic [6:0] cnt_n;
  logic [2:0] bank;
  logic [2:0] next_bank;
  logic [1:0] psel;
  logic [1:0] next_psel;
  logic prd;
  logic next_prd;
  logic [127:0] wbuf;
  logic [127:0] next_wbuf;
  logic [15:0] mbuf;
  logic [15:0] next_mbuf;
  logic [15:0] rxcrc;
  logic [15:0] next_rxcrc;
  logic [127:0] mem [8];
  logic [127:0] next_mem [8];
  logic [127:0] merged;
  ddp_pkg::ddp_link_out_t next_out;
  logic crc_fail;
  logic next_crc_fail;
  logic wgate;
  logic next_wgate;
  logic [7:0] tcnt;
  logic [7:0] next_tcnt;
  logic tready;
  logic next_tready;

  logic [4:0] wl;
  logic [4:0] rl;
  logic [7:0] wpre_edges;
  logic [7:0] rpre_edges;
  logic crc_en;
  logic dm_en;
  logic train_on;

  ddp_sync #(.W($bits(ddp_pkg::ddp_link_in_t))) ddp_sync_i (
    .clk(clk),
    .nrst(nrst),
    .d(link_in),
    .q(link_s)
  );

  // link clock is only sampled; its edges pace the write and read bursts
  assign rise = link_s.ck & ~ck_prev;
  assign fall = ~link_s.ck & ck_prev;
  assign edge_seen = rise | fall;

  assign wl = WL_TAB[5*mr2[`DDP_MR2_WL_LSB +: 3] +: 5];
  assign rl = mr0[`DDP_MR0_RL_LSB +: 5];
  assign wpre_edges = mr4[`DDP_MR4_WPRE_BIT] ? 8'h04 : 8'h02; // [R6] [R8]
  assign rpre_edges = mr4[`DDP_MR4_RPRE_BIT] ? 8'h04 : 8'h02; // [R7] [R8]
  assign crc_en = mr2[`DDP_MR2_CRC_BIT];
  // masking is ignored if inversion is also set
  assign dm_en = mr5[`DDP_MR5_DM_BIT] & ~mr5[`DDP_MR5_WDBI_BIT]; // [R23]
  assign train_on = mr4[`DDP_MR4_TRAIN_BIT] & pmode; // [R15]
  assign bus_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // per lane slot: slot k is transfer k/2, lane k%2
  genvar k;
  generate
    for (k = 0; k < 16; k++) begin : g_lane
      assign merged[8*k +: 8] = (dm_en && !mbuf[k]) ?
        mem[bank][8*k +: 8] : wbuf[8*k +: 8]; // [R1] [R2]
    end
  endgenerate

  always_comb begin
    rd_val = 32'h00000000;
    case (wb_adr_i)
      `DDP_OFF_MR0: rd_val = {18'h00000, mr0};
      `DDP_OFF_MR2: rd_val = {18'h00000, mr2};
      `DDP_OFF_MR4: rd_val = {18'h00000, mr4};
      `DDP_OFF_MR5: rd_val = {18'h00000, mr5};
      `DDP_OFF_PAT: rd_val = pat;
      `DDP_OFF_CTRL: rd_val = {31'h00000000, pmode};
      `DDP_OFF_STAT: rd_val = {28'h0000000, state != ddp_pkg::DDP_IDLE,
                               tready, wgate, dm_en};
      default: rd_val = 32'h00000000;
    endcase
    for (int b = 0; b < 4; b++) begin
      wr_val[8*b +: 8] = wb_sel_i[b] ? wb_dat_i[8*b +: 8] : rd_val[8*b +: 8];
    end
  end

  always_comb begin
    next_mr0 = mr0;
    next_mr2 = mr2;
    next_mr4 = mr4;
    next_mr5 = mr5;
    next_pat = pat;
    next_pmode = pmode;
    next_ack = bus_hit;
    next_dat_o = wb_dat_o;
    if (bus_hit && !wb_we_i) begin
      next_dat_o = rd_val;
    end
    if (bus_hit && wb_we_i) begin
      case (wb_adr_i)
        `DDP_OFF_MR0: next_mr0 = wr_val[13:0];
        `DDP_OFF_MR2: next_mr2 = wr_val[13:0];
        `DDP_OFF_MR4: next_mr4 = wr_val[13:0];
        `DDP_OFF_MR5: next_mr5 = wr_val[13:0];
        `DDP_OFF_PAT: next_pat = wr_val;
        `DDP_OFF_CTRL: next_pmode = wr_val[`DDP_CTRL_PMODE_BIT];
        default: next_pmode = pmode;
      endcase
    end
    // hardware set wins over a clearing write in the same cycle
    if (crc_fail) begin
      next_mr5[`DDP_MR5_CRCERR_BIT] = 1'b1; // [R24]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mr0 <= `DDP_MR0_RST;
      mr2 <= `DDP_MR2_RST;
      mr4 <= `DDP_MR4_RST;
      mr5 <= `DDP_MR5_RST;
      pat <= `DDP_PAT_RST;
      pmode <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      mr0 <= next_mr0;
      mr2 <= next_mr2;
      mr4 <= next_mr4;
      mr5 <= next_mr5;
      pat <= next_pat;
      pmode <= next_pmode;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat_o;
    end
  end

  always_comb begin
    logic signed [7:0] pos;
    logic [15:0] fold;
    logic [7:0] pbyte;
    pos = 8'sh00;
    fold = 16'h0000;
    pbyte = pat[8*psel +: 8];
    next_state = state;
    next_cnt = cnt;
    next_bank = bank;
    next_psel = psel;
    next_prd = prd;
    next_wbuf = wbuf;
    next_mbuf = mbuf;
    next_rxcrc = rxcrc;
    next_mem = mem;
    next_out = link_out;
    next_crc_fail = 1'b0;
    next_wgate = wgate;
    cnt_n = cnt + 7'h01;
    for (int t = 0; t < 8; t++) begin
      fold = fold ^ wbuf[16*t +: 16];
    end
    // settle timer, then data held high, strobe low until a pattern read
    next_tcnt = 8'h00;
    next_tready = 1'b0;
    if (train_on) begin
      next_tcnt = (tcnt == TRAINING_SETTLE_TIME_CYC) ? tcnt : tcnt + 8'h01;
      next_tready = (tcnt == TRAINING_SETTLE_TIME_CYC); // [R16]
    end
    case (state)
      ddp_pkg::DDP_IDLE: begin
        next_out = '0;
        if (tready) begin
          next_out.dq = 16'hFFFF; // [R16]
          next_out.dq_oe = 1'b1;
          next_out.dqs_c = 1'b1;
          next_out.dqs_oe = 1'b1;
        end
        if (rise && link_s.cmd == ddp_pkg::DDP_WRITE) begin
          next_state = ddp_pkg::DDP_WR;
          next_cnt = 7'h00;
          next_bank = {link_s.bank_group_bit, link_s.bank}; // [R18]
          next_wgate = 1'b0;
        end else if (rise && link_s.cmd == ddp_pkg::DDP_READ) begin
          next_state = ddp_pkg::DDP_RD;
          next_cnt = 7'h00;
          next_bank = {link_s.bank_group_bit, link_s.bank}; // [R18]
          next_psel = link_s.bank;
          next_prd = pmode;
        end
      end
      ddp_pkg::DDP_WR: begin
        if (edge_seen) begin
          next_cnt = cnt_n;
          pos = $signed({1'b0, cnt_n}) - $signed({2'b00, wl, 1'b0});
          // receiver opens at the start of the selected preamble
          if (pos >= -$signed(wpre_edges)) begin
            next_wgate = 1'b1; // [R6]
          end
          if (pos >= 8'sh00 && pos <= 8'sh07) begin
            next_wbuf[16*pos[2:0] +: 16] = link_s.dq; // [R5]
            next_mbuf[2*pos[2:0]] = link_s.lower_lane_mask; // [R5]
            next_mbuf[2*pos[2:0]+1] = link_s.upper_lane_mask; // [R5]
          end
          if (pos == 8'sh08) begin
            next_rxcrc = link_s.dq;
          end
          if (pos == (crc_en ? 8'sh09 : 8'sh07)) begin
            next_state = ddp_pkg::DDP_COMMIT;
          end
        end
      end
      ddp_pkg::DDP_COMMIT: begin
        next_state = ddp_pkg::DDP_IDLE;
        next_wgate = 1'b0;
        if (crc_en && rxcrc != fold) begin
          next_crc_fail = 1'b1; // [R24]
          if (!dm_en) begin
            next_mem[bank] = merged; // [R4]
          end
          // masking on: nothing of the burst lands
        end else begin
          next_mem[bank] = merged; // [R1] [R2] [R3]
        end
      end
      ddp_pkg::DDP_RD: begin
        if (edge_seen) begin
          next_cnt = cnt_n;
          pos = $signed({1'b0, cnt_n}) - $signed({2'b00, rl, 1'b0});
          if (pos < 8'sh00 && pos >= -$signed(rpre_edges)) begin
            next_out = '0; // [R7]
            next_out.dqs_c = 1'b1;
            next_out.dqs_oe = 1'b1;
          end else if (pos >= 8'sh00 && pos <= 8'sh07) begin
            next_out.dq = prd ? {16{pbyte[pos[2:0]]}} :
              mem[bank][16*pos[2:0] +: 16]; // [R5] [R16]
            next_out.dq_oe = 1'b1;
            next_out.dqs_t = ~pos[0];
            next_out.dqs_c = pos[0];
            next_out.dqs_oe = 1'b1;
          end else if (pos == 8'sh08) begin
            next_out.dq_oe = 1'b0; // [R17]
            next_out.dqs_t = 1'b0;
            next_out.dqs_c = 1'b1;
          end else if (pos == 8'sh09) begin
            next_out = '0; // [R17]
            next_state = ddp_pkg::DDP_IDLE;
          end
        end
      end
      default: next_state = ddp_pkg::DDP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ck_prev <= 1'b0;
      state <= ddp_pkg::DDP_IDLE;
      cnt <= 7'h00;
      bank <= 3'h0;
      psel <= 2'h0;
      prd <= 1'b0;
      wbuf <= '0;
      mbuf <= 16'h0000;
      rxcrc <= 16'h0000;
      for (int i = 0; i < 8; i++) begin
        mem[i] <= '0;
      end
      link_out <= '0;
      crc_fail <= 1'b0;
      wgate <= 1'b0;
      tcnt <= 8'h00;
      tready <= 1'b0;
    end else begin
      ck_prev <= link_s.ck;
      state <= next_state;
      cnt <= next_cnt;
      bank <= next_bank;
      psel <= next_psel;
      prd <= next_prd;
      wbuf <= next_wbuf;
      mbuf <= next_mbuf;
      rxcrc <= next_rxcrc;
      mem <= next_mem;
      link_out <= next_out;
      crc_fail <= next_crc_fail;
      wgate <= next_wgate;
      tcnt <= next_tcnt;
      tready <= next_tready;
    end
  end
endmodule

// file: test/ddp_properties.sv
module ddp_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire ddp_pkg::ddp_link_in_t link_in,
  input wire ddp_pkg::ddp_link_out_t link_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_ack_timely: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o)
    else $error("ack late");
  a_rdata_hold: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i)
    |=> $stable(wb_dat_o))
    else $error("read data moved without read");
  a_strobe_pair: assert property (
    link_out.dqs_oe |-> link_out.dqs_t != link_out.dqs_c)
    else $error("strobes not complementary");
  a_data_strobed: assert property (
    link_out.dq_oe |-> link_out.dqs_oe)
    else $error("data driven without strobe");
  a_strobe_toggle: assert property (
    $rose(link_out.dqs_t) |-> ##[1:8] !link_out.dqs_t)
    else $error("strobe stuck high");
  // half a link clock is four system clocks
  a_post_half: assert property (
    $fell(link_out.dq_oe) && link_out.dqs_oe |-> link_out.dqs_oe [*2]
    ##[1:8] (!link_out.dqs_oe || link_out.dq_oe))
    else $error("postamble length wrong");
endmodule

bind ddp_top ddp_properties ddp_properties_i (
  .clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .link_in, .link_out
);

// file: test/ddp_ctrl_model.sv
module ddp_ctrl_model (
  input wire logic clk,
  output ddp_pkg::ddp_link_in_t link,
  input wire ddp_pkg::ddp_link_out_t lo
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] wd [0:9];
  logic [1:0] wm [0:9];
  ddp_pkg::ddp_link_out_t cap [0:38];
  initial link = '0;
  // ck only moves inside a frame, every fourth clk; data changes mid-half
  // 40 edges a frame: 20 link clocks between commands, far over minimums
  task automatic frame(input ddp_pkg::ddp_cmd_t c, input logic [2:0] b,
    input int lat);
    int k;
    link.cmd <= c;
    {link.bank_group_bit, link.bank} <= b;
    for (int e = 0; e < 40; e++) begin
      k = e - 2 * lat;
      if (e == 1) link.cmd <= ddp_pkg::DDP_NOP;
      link.dq <= (k >= 0 && k < 10) ? wd[k] : 16'hA5A5 ^ {16{e[0]}};
      {link.upper_lane_mask, link.lower_lane_mask} <=
        (k >= 0 && k < 10) ? wm[k] : 2'(e);
      repeat (2) @(posedge clk);
      link.ck <= !link.ck;
      repeat (2) @(posedge clk);
      if (e > 0) cap[e - 1] = lo;
    end
  endtask
endmodule

// file: test/test_ddp_top.sv
module test_ddp_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam ddp_pkg::ddp_cmd_t WR = ddp_pkg::DDP_WRITE;
  localparam ddp_pkg::ddp_cmd_t RD = ddp_pkg::DDP_READ;
  logic clk, nrst, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, dat, rdat;
  logic [15:0] em [0:7][0:7];
  logic [15:0] ex [0:7];
  logic [7:0] pb = 8'h96;
  ddp_pkg::ddp_link_in_t li;
  ddp_pkg::ddp_link_out_t lo;
  int err_total = 0;
  int total_checks = 0;
  int cyc_n = 0;
  ddp_top ddp_top_i (.clk, .nrst, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat), .wb_ack_o(ack), .link_in(li), .link_out(lo));
  ddp_ctrl_model ddp_ctrl_model_i (.clk, .link(li), .lo);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_total++;
      results();
    end
  end
  task automatic results();
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // only ack or the global cycle ceiling ends a wait
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rdat = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    cmp($sformatf("reg%h", a), e, rdat);
  endtask
  // st: 0 nothing lands, 1 whole burst, 2 lanes by mask
  task automatic burst(input ddp_pkg::ddp_cmd_t c, input logic [2:0] b,
    input int lat, input logic [15:0] s, input logic [1:0] m,
    input logic bad, input int st);
    logic [15:0] x, d;
    logic [1:0] k;
    x = 16'h0;
    for (int i = 0; i < 8; i++) begin
      d = s ^ {4{4'(i)}};
      k = m ^ 2'(i);
      ddp_ctrl_model_i.wd[i] = d;
      ddp_ctrl_model_i.wm[i] = k;
      x ^= d;
      if (st == 1) em[b][i] = d;
      if (st == 2 && k[0]) em[b][i][7:0] = d[7:0];
      if (st == 2 && k[1]) em[b][i][15:8] = d[15:8];
    end
    ddp_ctrl_model_i.wd[8] = x ^ {15'h0, bad};
    ddp_ctrl_model_i.wd[9] = 16'hFFFF;
    ddp_ctrl_model_i.wm[8] = 2'h3;
    ddp_ctrl_model_i.wm[9] = 2'h3;
    ddp_ctrl_model_i.frame(c, b, lat);
    @(posedge clk);
  endtask
  // pre 0: training, idle levels are driven so edges are skipped
  task automatic chk(input logic [2:0] b, input int pre);
    ddp_pkg::ddp_link_out_t v;
    logic [3:0] s;
    burst(RD, b, 11, 16'h0, 2'h0, 1'b0, 0);
    for (int e = 21 - pre; e < 32; e++) begin
      v = ddp_ctrl_model_i.cap[e];
      s = {v.dq_oe, v.dqs_t, v.dqs_c, v.dqs_oe};
      if (e >= 22 && e < 30) begin
        cmp("strobe", {1'b1, !e[0], e[0], 1'b1}, s);
        cmp("dq", ex[e - 22], v.dq);
      end else if (pre > 0 && (e == 21 - pre || e == 31))
        cmp("off", 0, v.dqs_oe);
      else if (pre > 0)
        cmp("prepost", 4'h3, s);
    end
  endtask
  initial begin
    {cyc, stb, we, adr, wdat, nrst} = '0;
    sel = 4'hF;
    em = '{default: '{default: 16'h0}};
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h00, 32'h00B0);
    wb(1'b1, 8'h18, 32'hF);
    wb(1'b1, 8'h1C, 32'hFFFF);
    rd(8'h18, 32'h0);
    rd(8'h1C, 32'h0);
    burst(WR, 3'h3, 9, 16'h1234, 2'h0, 1'b0, 1);
    ex = em[3];
    chk(3'h3, 2);
    wb(1'b1, 8'h0C, 32'h0C00);
    rd(8'h18, 32'h0);
    wb(1'b1, 8'h0C, 32'h0400);
    rd(8'h18, 32'h1);
    burst(WR, 3'h7, 9, 16'hC3A0, 2'h0, 1'b0, 2);
    ex = em[7];
    chk(3'h7, 2);
    ex = em[3];
    chk(3'h3, 2);
    wb(1'b1, 8'h04, 32'h1000);
    burst(WR, 3'h7, 9, 16'h7777, 2'h2, 1'b1, 0);
    rd(8'h0C, 32'h0408);
    ex = em[7];
    chk(3'h7, 2);
    wb(1'b1, 8'h0C, 32'h0000);
    rd(8'h0C, 32'h0000);
    wb(1'b1, 8'h04, 32'h1008);
    burst(WR, 3'h3, 10, 16'hBEEF, 2'h0, 1'b1, 1);
    rd(8'h0C, 32'h0008);
    ex = em[3];
    chk(3'h3, 2);
    wb(1'b1, 8'h0C, 32'h0000);
    wb(1'b1, 8'h04, 32'h0020);
    wb(1'b1, 8'h08, 32'h1800);
    rd(8'h08, 32'h1800);
    burst(WR, 3'h3, 14, 16'h2468, 2'h1, 1'b0, 1);
    ex = em[3];
    chk(3'h3, 4);
    wb(1'b1, 8'h08, 32'h0400);
    repeat (4) @(posedge clk);
    cmp("idle", 0, lo.dqs_oe);
    wb(1'b1, 8'h14, 32'h1);
    repeat (4) @(posedge clk);
    cmp("train", 20'hFFFFB, lo);
    rd(8'h18, 32'h4);
    wb(1'b1, 8'h10, 32'hC35A96F0);
    for (int i = 0; i < 8; i++) ex[i] = {16{pb[i]}};
    chk(3'h1, 0);
    wb(1'b1, 8'h08, 32'h0);
    wb(1'b1, 8'h14, 32'h0);
    results();
  end
endmodule
